//--- rtl/e1tx_ovh_insert.v
// Top of the E1 transmit overhead inserter: registers, settings shadow and byte rewrite
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_regs.vh"

module e1tx_ovh_insert (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire [10:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output wire [7:0] REG_RDATA_O,
  input wire [7:0] RX_CRC_ERR_I,
  input wire [7:0] RX_CRC_ERR_SMF2_I,
  input wire [7:0] RX_CRC_MF_LOST_I,
  input wire IN_VALID_I,
  output wire IN_READY_O,
  input wire [2:0] IN_CHAN_I,
  input wire [4:0] IN_TS_I,
  input wire [3:0] IN_FRAME_I,
  input wire [3:0] IN_SIG_FRAME_I,
  input wire [7:0] IN_DATA_I,
  output wire OUT_VALID_O,
  input wire OUT_READY_I,
  output wire [2:0] OUT_CHAN_O,
  output wire [4:0] OUT_TS_O,
  output wire [3:0] OUT_FRAME_O,
  output wire [7:0] OUT_DATA_O
);

  // ****************************************************************
  // Register field packing
  // ****************************************************************

  // Merge one written register byte into a channel's packed settings
  function [`E1TX_CFG_W-1:0] cfg_wr;
    input [`E1TX_CFG_W-1:0] v;
    input [7:0] off;
    input [7:0] d;
    reg [`E1TX_CFG_W-1:0] n;
    begin
      n = v;
      case (off)
        `E1TX_OFF_MODE: n[`E1TX_CF_XOFF:`E1TX_CF_FGOFF] = d[6:0];
        `E1TX_OFF_INTL: n[`E1TX_CF_NFASI:`E1TX_CF_FASI] = d[1:0];
        `E1TX_OFF_SACTL: n[`E1TX_CF_SACTL+4:`E1TX_CF_SACTL] = d[4:0];
        `E1TX_OFF_CW4: n[`E1TX_CF_CW+3:`E1TX_CF_CW] = d[3:0];
        `E1TX_OFF_CW5: n[`E1TX_CF_CW+7:`E1TX_CF_CW+4] = d[3:0];
        `E1TX_OFF_CW6: n[`E1TX_CF_CW+11:`E1TX_CF_CW+8] = d[3:0];
        `E1TX_OFF_CW7: n[`E1TX_CF_CW+15:`E1TX_CF_CW+12] = d[3:0];
        `E1TX_OFF_CW8: n[`E1TX_CF_CW+19:`E1TX_CF_CW+16] = d[3:0];
        `E1TX_OFF_EXTRA: n[`E1TX_CF_X+2:`E1TX_CF_X] = {d[3], d[1:0]};
        default: n = v;
      endcase
      cfg_wr = n;
    end
  endfunction

  // Unpack a register byte; reserved bits read as zero
  function [7:0] cfg_rd;
    input [`E1TX_CFG_W-1:0] v;
    input [7:0] off;
    begin
      case (off)
        `E1TX_OFF_MODE: cfg_rd = {1'b0, v[`E1TX_CF_XOFF:`E1TX_CF_FGOFF]};
        `E1TX_OFF_INTL: cfg_rd = {6'h00, v[`E1TX_CF_NFASI:`E1TX_CF_FASI]};
        `E1TX_OFF_SACTL: cfg_rd = {3'h0, v[`E1TX_CF_SACTL+4:`E1TX_CF_SACTL]};
        `E1TX_OFF_CW4: cfg_rd = {4'h0, v[`E1TX_CF_CW+3:`E1TX_CF_CW]};
        `E1TX_OFF_CW5: cfg_rd = {4'h0, v[`E1TX_CF_CW+7:`E1TX_CF_CW+4]};
        `E1TX_OFF_CW6: cfg_rd = {4'h0, v[`E1TX_CF_CW+11:`E1TX_CF_CW+8]};
        `E1TX_OFF_CW7: cfg_rd = {4'h0, v[`E1TX_CF_CW+15:`E1TX_CF_CW+12]};
        `E1TX_OFF_CW8: cfg_rd = {4'h0, v[`E1TX_CF_CW+19:`E1TX_CF_CW+16]};
        `E1TX_OFF_EXTRA: cfg_rd = {4'h0, v[`E1TX_CF_X+2], 1'b0, v[`E1TX_CF_X+1:`E1TX_CF_X]};
        default: cfg_rd = 8'h00;
      endcase
    end
  endfunction

  // Spare bit from a codeword: bit [3] alone without the CRC
  // multiframe, else the bit for the frame's place in its half
  function sa_pick;
    input [3:0] word;
    input crc;
    input [1:0] pos;
    begin
      if (crc) begin
        sa_pick = word[2'h3 - pos];
      end else begin
        sa_pick = word[3];
      end
    end
  endfunction

  // ****************************************************************
  // Reset image of one channel's settings
  // ****************************************************************

  // Codewords and extra bits come up as ones, CRC and signalling on
  localparam [`E1TX_CFG_W-1:0] cfg_rst_val = {`E1TX_RST_X, {5{`E1TX_RST_CW}},
    `E1TX_RST_SACTL, `E1TX_RST_INTL, `E1TX_RST_MODE};

  // ****************************************************************
  // State
  // ****************************************************************
  reg [`E1TX_CFG_W-1:0] cfg_r [0:7];
  reg [`E1TX_CFG_W-1:0] act_r [0:7];
  reg [7:0] pend1_r;
  reg [7:0] pend2_r;
  reg [7:0] rdata_r;
  reg [7:0] pend1_nxt;
  reg [7:0] pend2_nxt;
  reg [7:0] byte_nxt;
  reg [`E1TX_CFG_W-1:0] cur;
  reg [3:0] cw;
  reg fg_off, crc_on, sig_on, basic_on, e_pend, si_val;
  integer g;
  integer c;
  wire [2:0] reg_chan;
  wire [7:0] reg_off;
  wire push;
  wire in_ready;
  wire boundary;
  wire [`E1TX_BUF_W-1:0] buf_out;
  wire e1_slot;
  wire e2_slot;
  wire [7:0] mfas_pat;

  assign reg_chan = REG_ADDR_I[`E1TX_CHAN_MSB:`E1TX_CHAN_LSB];
  assign reg_off = REG_ADDR_I[7:0];
  assign IN_READY_O = in_ready;
  assign push = IN_VALID_I & in_ready;
  assign REG_RDATA_O = rdata_r;

  // Frame 0 timeslot 0 opens a multiframe; settings are swapped only there
  assign boundary = (IN_TS_I == `E1TX_TS_ALIGN) && (IN_FRAME_I == 4'h0);

  // ****************************************************************
  // Slot decode
  // ****************************************************************

  // Accepted timeslot 0 of the frames that carry E1 and E2
  assign e1_slot = push && (IN_TS_I == `E1TX_TS_ALIGN) && (IN_FRAME_I == `E1TX_E1_FRAME);
  assign e2_slot = push && (IN_TS_I == `E1TX_TS_ALIGN) && (IN_FRAME_I == `E1TX_E2_FRAME);

  // Alignment word bits for frames 1 to 11, lowest bit first
  assign mfas_pat = `E1TX_MFAS_PAT;

  // ****************************************************************
  // Register writes, shadow copy and read port
  // ****************************************************************

  // Live settings per channel; the shadow copy is what the stream uses
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      for (c = 0; c < 8; c = c + 1) begin
        cfg_r[c] <= cfg_rst_val;
        act_r[c] <= cfg_rst_val;
      end
    end else begin
      if (REG_WR_I) begin
        cfg_r[reg_chan] <= cfg_wr(cfg_r[reg_chan], reg_off, REG_WDATA_I);
      end
      if (push && boundary) begin
        act_r[IN_CHAN_I] <= cfg_r[IN_CHAN_I];
      end
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rdata_r <= 8'h00;
    end else if (REG_RD_I) begin
      // Status: owed E2, owed E1, sync lost, low five active mode bits
      if (reg_off == `E1TX_OFF_STATUS) begin
        rdata_r <= {pend2_r[reg_chan], pend1_r[reg_chan], RX_CRC_MF_LOST_I[reg_chan],
                    act_r[reg_chan][`E1TX_CF_FEB:`E1TX_CF_FGOFF]};
      end else begin
        rdata_r <= cfg_rd(cfg_r[reg_chan], reg_off);
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ****************************************************************
  // Receive CRC error bookkeeping
  // ****************************************************************

  // One pending zero per submultiframe; several errors in one collapse
  always @* begin
    pend1_nxt = pend1_r;
    pend2_nxt = pend2_r;
    // A zero is spent at its E slot even when the mode does not send it
    if (e1_slot) begin
      pend1_nxt[IN_CHAN_I] = 1'b0;
    end
    if (e2_slot) begin
      pend2_nxt[IN_CHAN_I] = 1'b0;
    end
    // A new error beats the consuming clear in the same cycle
    pend1_nxt = pend1_nxt | (RX_CRC_ERR_I & ~RX_CRC_ERR_SMF2_I);
    pend2_nxt = pend2_nxt | (RX_CRC_ERR_I & RX_CRC_ERR_SMF2_I);
  end

  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pend1_r <= 8'h00;
      pend2_r <= 8'h00;
    end else begin
      pend1_r <= pend1_nxt;
      pend2_r <= pend2_nxt;
    end
  end

  // ****************************************************************
  // Overhead rewrite of one timeslot byte (bit 1 is the MSB)
  // ****************************************************************

  // Settings taken at the boundary byte already apply to that byte
  always @* begin
    cur = boundary ? cfg_r[IN_CHAN_I] : act_r[IN_CHAN_I];
    byte_nxt = IN_DATA_I;
    cw = 4'h0;
    fg_off = cur[`E1TX_CF_FGOFF];
    basic_on = ~fg_off;
    crc_on = ~fg_off & cur[`E1TX_CF_CRC];
    sig_on = ~fg_off & cur[`E1TX_CF_SIG];
    // Frame 13 carries E1 for the first half, frame 15 E2 for the second
    e_pend = (IN_FRAME_I == `E1TX_E1_FRAME) ? pend1_r[IN_CHAN_I] : pend2_r[IN_CHAN_I];
    si_val = (IN_FRAME_I == `E1TX_E1_FRAME) ? cur[`E1TX_CF_FASI] : cur[`E1TX_CF_NFASI];
    if (basic_on && IN_TS_I == `E1TX_TS_ALIGN) begin
      if (!IN_FRAME_I[0]) begin
        // Frame alignment frame
        byte_nxt[6:0] = `E1TX_FAS_PAT;
        if (crc_on) begin
          // CRC bits come from upstream; the modified form sends ones
          if (cur[`E1TX_CF_MCRC]) begin
            byte_nxt[7] = 1'b1;
          end
        end else if (!cur[`E1TX_CF_SID]) begin
          byte_nxt[7] = cur[`E1TX_CF_FASI];
        end
      end else begin
        // Non-alignment frame: fixed one, alarm bit passes through
        byte_nxt[6] = 1'b1;
        if (crc_on) begin
          if (IN_FRAME_I[3:1] < 3'h6) begin
            // Frames 1 to 11 carry the multiframe alignment word
            byte_nxt[7] = mfas_pat[IN_FRAME_I[3:1]];
          end else if (!cur[`E1TX_CF_FEB] && !RX_CRC_MF_LOST_I[IN_CHAN_I]) begin
            // Sync held: an owed zero goes out, several errors give one zero
            byte_nxt[7] = ~e_pend;
          end else if (!cur[`E1TX_CF_FEB] || !cur[`E1TX_CF_SID]) begin
            // Sync lost, or error reporting off with international values on
            byte_nxt[7] = si_val;
          end else begin
            byte_nxt[7] = IN_DATA_I[7];
          end
        end else if (!cur[`E1TX_CF_SID]) begin
          byte_nxt[7] = cur[`E1TX_CF_NFASI];
        end
        // National spare bits Sa4..Sa8 sit in byte bits 4 down to 0
        for (g = 0; g < 5; g = g + 1) begin
          cw = cur[`E1TX_CF_CW + 4*g +: 4];
          if (cur[`E1TX_CF_SACTL + 4 - g]) begin
            byte_nxt[4-g] = sa_pick(cw, crc_on, IN_FRAME_I[2:1]);
          end
        end
      end
    end
    // Signalling multiframe alignment and extra bits in TS16 frame 0
    if (sig_on && IN_TS_I == `E1TX_TS_SIG && IN_SIG_FRAME_I == 4'h0) begin
      byte_nxt[7:4] = 4'h0;
      if (!cur[`E1TX_CF_XOFF]) begin
        byte_nxt[3] = cur[`E1TX_CF_X+2];
        byte_nxt[1:0] = cur[`E1TX_CF_X+1:`E1TX_CF_X];
      end
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************

  // Two words of slack keep a receiver stall from dropping a byte
  e1tx_skid_buf #(
    .W(`E1TX_BUF_W)
  ) u_buf (
    .CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I),
    .in_valid_i(IN_VALID_I),
    .in_ready_o(in_ready),
    .in_data_i({IN_CHAN_I, IN_TS_I, IN_FRAME_I, byte_nxt}),
    .out_valid_o(OUT_VALID_O),
    .out_ready_i(OUT_READY_I),
    .out_data_o(buf_out)
  );

  // Buffer word: channel, timeslot, frame, rewritten byte
  assign OUT_CHAN_O = buf_out[19:17];
  assign OUT_TS_O = buf_out[16:12];
  assign OUT_FRAME_O = buf_out[11:8];
  assign OUT_DATA_O = buf_out[7:0];

endmodule

`default_nettype wire

//--- rtl/e1tx_regs.vh
// Register map, field positions and reset values of the E1 transmit overhead inserter
//
// Behaviour
// - Eight channel copies, each 0x100 apart
// - Signalling multiframe overwrites TS16 frame-0 extra bits
// - Basic frame replaces international bit from values
// - CRC multiframe: receive CRC error gives one E zero
// - Sync lost or disabled far error: E from values
// - Both disables set: E bits left untouched
// - Multiframe selects act only with framing enabled
// - Modified CRC multiframe only with CRC multiframe
// - Framing disable stops all framing generation
// - Spare insert enables act only with basic frame
// - Basic only: first codeword bit every frame
// - CRC multiframe: four codeword bits per submultiframe
// - Sa4 to Sa8 codewords reset to ones
// - Extra bit values reset to ones, replace TS16
`ifndef E1TX_REGS_VH
`define E1TX_REGS_VH

// ****************************************************************
// Address layout
// ****************************************************************
`define E1TX_CHAN_MSB 10
`define E1TX_CHAN_LSB 8
`define E1TX_OFF_MODE 8'h62
`define E1TX_OFF_INTL 8'h63
`define E1TX_OFF_SACTL 8'h64
`define E1TX_OFF_CW4 8'h65
`define E1TX_OFF_CW5 8'h66
`define E1TX_OFF_CW6 8'h67
`define E1TX_OFF_CW7 8'h68
`define E1TX_OFF_CW8 8'h69
`define E1TX_OFF_EXTRA 8'h6A
`define E1TX_OFF_STATUS 8'h70

// ****************************************************************
// Packed per-channel configuration vector
// ****************************************************************
`define E1TX_CFG_W 37
`define E1TX_CF_FGOFF 0
`define E1TX_CF_CRC 1
`define E1TX_CF_SIG 2
`define E1TX_CF_MCRC 3
`define E1TX_CF_FEB 4
`define E1TX_CF_SID 5
`define E1TX_CF_XOFF 6
`define E1TX_CF_FASI 7
`define E1TX_CF_NFASI 8
`define E1TX_CF_SACTL 9
`define E1TX_CF_CW 14
`define E1TX_CF_X 34

// ****************************************************************
// Reset values and frame constants
// ****************************************************************
`define E1TX_RST_MODE 7'h06
`define E1TX_RST_INTL 2'h3
`define E1TX_RST_SACTL 5'h00
`define E1TX_RST_CW 4'hF
`define E1TX_RST_X 3'h7
`define E1TX_FAS_PAT 7'h1B
`define E1TX_MFAS_PAT 8'h34
`define E1TX_E1_FRAME 4'hD
`define E1TX_E2_FRAME 4'hF
`define E1TX_TS_ALIGN 5'h00
`define E1TX_TS_SIG 5'h10
`define E1TX_BUF_W 20

`endif

//--- rtl/e1tx_skid_buf.v
// Two-entry buffer between the overhead inserter and the line side
`timescale 1ns/1ps
`default_nettype none

module e1tx_skid_buf #(
  parameter W = 20
) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] ent0_r;
  reg [W-1:0] ent1_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  // Full at two words, so a stalled receiver pushes back on the source
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = ent0_r;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Entry 0 is always the head; entry 1 only holds the second word
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ent0_r <= {W{1'b0}};
      ent1_r <= {W{1'b0}};
      cnt_r <= 2'h0;
    end else begin
      if (push && !pop) begin
        if (cnt_r == 2'h0) begin
          ent0_r <= in_data_i;
        end else begin
          ent1_r <= in_data_i;
        end
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        ent0_r <= ent1_r;
        cnt_r <= cnt_r - 2'h1;
      end else if (pop && push) begin
        ent0_r <= in_data_i;
      end
    end
  end

endmodule

`default_nettype wire

//--- dv/e1tx_line_sink.sv
// Line-side receiver model that collects the words leaving the inserter
`timescale 1ns/1ps
`default_nettype none
module e1tx_line_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [2:0] chan_i,
  input wire logic [4:0] ts_i,
  input wire logic [7:0] data_i,
  output logic ready_o
);
  // ****************************************************************
  // Capture
  // ****************************************************************
  logic [15:0] got [$];
  // Stalls only when told, so both a prompt and a slow line can be played
  assign ready_o = rst_n_i && !stall_i;
  // A word is taken at the edge where valid meets ready
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      got.push_back({chan_i, ts_i, data_i});
    end
  end
endmodule
`default_nettype wire

//--- dv/e1tx_ovh_chk.sv
// Port checker for the E1 transmit overhead inserter
`timescale 1ns/1ps
`default_nettype none
module e1tx_ovh_chk (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic IN_VALID_I,
  input wire logic IN_READY_O,
  input wire logic [4:0] IN_TS_I,
  input wire logic [3:0] IN_FRAME_I,
  input wire logic [3:0] IN_SIG_FRAME_I,
  input wire logic [7:0] IN_DATA_I,
  input wire logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  input wire logic [4:0] OUT_TS_O,
  input wire logic [3:0] OUT_FRAME_O,
  input wire logic [7:0] OUT_DATA_O
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Byte taken into an empty buffer; it must show one cycle later
  wire tk = IN_VALID_I && IN_READY_O && !OUT_VALID_O;
  wire ts0 = tk && IN_TS_I == 5'h00;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  rd_quiet_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside its slot");
  full_only_a: assert property (!IN_READY_O |-> OUT_VALID_O)
    else $error("ready low with empty buffer");
  out_hold_a: assert property (OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O))
    else $error("stalled word changed");
  fill_lat_a: assert property (tk |=> OUT_VALID_O && OUT_TS_O == $past(IN_TS_I)
    && OUT_FRAME_O == $past(IN_FRAME_I))
    else $error("word late or mislabelled");
  payload_a: assert property (tk && IN_TS_I != 5'h00 && IN_TS_I != 5'h10
    |=> OUT_DATA_O == $past(IN_DATA_I))
    else $error("payload slot altered");
  fas_word_a: assert property (ts0 && !IN_FRAME_I[0]
    |=> OUT_DATA_O[6:0] == 7'h1B || OUT_DATA_O == $past(IN_DATA_I))
    else $error("bad alignment word");
  nfas_one_a: assert property (ts0 && IN_FRAME_I[0]
    |=> OUT_DATA_O[6] || OUT_DATA_O == $past(IN_DATA_I))
    else $error("bad fixed one in odd frame");
  abit_pass_a: assert property (ts0 && IN_FRAME_I[0]
    |=> ((OUT_DATA_O ^ $past(IN_DATA_I)) & 8'h20) == 8'h00)
    else $error("alarm bit altered");
  sig_word_a: assert property (tk && IN_TS_I == 5'h10 && IN_SIG_FRAME_I == 4'h0
    |=> OUT_DATA_O[7:4] == 4'h0 || OUT_DATA_O == $past(IN_DATA_I))
    else $error("bad signalling alignment");
endmodule

bind e1tx_ovh_insert e1tx_ovh_chk u_chk (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .IN_VALID_I(IN_VALID_I), .IN_READY_O(IN_READY_O), .IN_TS_I(IN_TS_I),
  .IN_FRAME_I(IN_FRAME_I), .IN_SIG_FRAME_I(IN_SIG_FRAME_I), .IN_DATA_I(IN_DATA_I),
  .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I), .OUT_TS_O(OUT_TS_O),
  .OUT_FRAME_O(OUT_FRAME_O), .OUT_DATA_O(OUT_DATA_O)
);
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the E1 transmit overhead inserter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] err = 8'h00;
  logic [7:0] err2 = 8'h00;
  logic [7:0] lost = 8'h00;
  logic in_valid = 1'b0;
  logic [2:0] in_chan = 3'h0;
  logic [4:0] in_ts = 5'h00;
  logic [3:0] in_fr = 4'h0;
  logic [3:0] in_sf = 4'h0;
  logic [7:0] in_data = 8'h00;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  wire [7:0] rdata;
  wire in_ready, out_valid, out_ready;
  wire [2:0] out_chan;
  wire [4:0] out_ts;
  wire [3:0] out_fr;
  wire [7:0] out_data;
  logic [31:0] seed = 32'hA75D;
  logic [31:0] st = 32'hA75D;
  // Channel 0 settings as software last wrote them, starting at reset values
  logic [7:0] mir [0:8] = '{8'h06, 8'h03, 8'h00, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0B};
  logic [7:0] modes [0:12] = '{8'h00, 8'h20, 8'h01, 8'h03, 8'h08, 8'h04, 8'h02, 8'h0A,
    8'h12, 8'h32, 8'h06, 8'h46, 8'h02};
  logic [7:0] d, e;
  integer n_fail = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i, c;

  e1tx_ovh_insert dut (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
    .RX_CRC_ERR_I(err), .RX_CRC_ERR_SMF2_I(err2), .RX_CRC_MF_LOST_I(lost),
    .IN_VALID_I(in_valid), .IN_READY_O(in_ready), .IN_CHAN_I(in_chan), .IN_TS_I(in_ts),
    .IN_FRAME_I(in_fr), .IN_SIG_FRAME_I(in_sf), .IN_DATA_I(in_data),
    .OUT_VALID_O(out_valid), .OUT_READY_I(out_ready), .OUT_CHAN_O(out_chan),
    .OUT_TS_O(out_ts), .OUT_FRAME_O(out_fr), .OUT_DATA_O(out_data));
  e1tx_line_sink sink (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .valid_i(out_valid),
    .chan_i(out_chan), .ts_i(out_ts), .data_i(out_data), .ready_o(out_ready));

  // ****************************************************************
  // Clock, stall pattern and run ceiling
  // ****************************************************************
  always #5 clk = ~clk;
  // Own generator for stalls, so the main sequence keeps a fixed draw order
  always @(posedge clk) begin
    st <= lfsr(st);
    stall <= hold || (slow && st[0]);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] rnd();
    repeat (8) seed = lfsr(seed);
    rnd = seed[7:0];
  endfunction
  // Expected channel 0 byte from the settings mirror; p is a pending receive error
  function automatic [7:0] tx(input [4:0] t, input [3:0] f, input [3:0] s, input [7:0] d,
      input p);
    logic [7:0] m;
    logic [4:0] sa;
    logic si, eb, nb;
    integer k;
    begin
      m = mir[0];
      for (k = 0; k < 5; k++) begin
        sa[4-k] = mir[2][4-k] ? mir[3+k][m[1] ? 3 - f[2:1] : 3] : d[4-k];
      end
      si = f[1] ? mir[1][1] : mir[1][0];
      eb = m[4] ? (m[5] ? d[7] : si) : (lost[0] ? si : !p);
      nb = !m[1] ? (m[5] ? d[7] : mir[1][1]) : (f < 4'hC ? 6'h34 >> f[3:1] : eb);
      tx = d;
      if (!m[0] && t == 5'h00 && !f[0]) begin
        tx = {m[1] ? (m[3] | d[7]) : (m[5] ? d[7] : mir[1][0]), 7'h1B};
      end else if (!m[0] && t == 5'h00) begin
        tx = {nb, 1'b1, d[5], sa};
      end else if (!m[0] && m[2] && t == 5'h10 && s == 4'h0) begin
        tx = {4'h0, m[6] ? d[3] : mir[8][3], d[2], m[6] ? d[1:0] : mir[8][1:0]};
      end
    end
  endfunction

  // ****************************************************************
  // Bus, stream and compare tasks
  // ****************************************************************
  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task automatic wr(input [10:0] a, input [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      if (a[10:4] == 7'h06 && a[3:0] > 4'h1 && a[3:0] < 4'hB) begin
        mir[a[3:0] - 4'h2] = v;
      end
    end
  endtask
  task automatic chk_rd(input [10:0] a, input [7:0] x);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      cmp({8'h00, rdata}, {8'h00, x});
    end
  endtask
  // Valid is dropped after the taking edge, so each call starts one edge later
  task automatic send(input [4:0] t, input [3:0] f, input [3:0] s, input [7:0] v);
    begin
      @(posedge clk);
      in_ts <= t;
      in_fr <= f;
      in_sf <= s;
      in_data <= v;
      in_valid <= 1'b1;
      do @(negedge clk); while (!in_ready);
      @(posedge clk);
      in_valid <= 1'b0;
    end
  endtask
  task automatic chk_out(input [15:0] x);
    integer k;
    begin
      for (k = 0; k < 40 && sink.got.size() == 0; k++) begin
        @(posedge clk);
      end
      cmp(sink.got.size() > 0 ? sink.got.pop_front() : 16'hXXXX, x);
    end
  endtask
  task automatic pulse(input s2);
    begin
      @(posedge clk);
      err <= 8'h01;
      err2 <= {7'h00, s2};
      @(posedge clk);
      err <= 8'h00;
    end
  endtask
  // One full multiframe of alignment, signalling and payload slots on channel 0
  task automatic mf(input [1:0] pend);
    integer f, j;
    logic [4:0] t;
    logic [7:0] v;
    begin
      for (f = 0; f < 16; f++) begin
        for (j = 0; j < 3; j++) begin
          t = (j == 0) ? 5'h00 : (j == 1) ? 5'h10 : 5'h05;
          v = rnd();
          send(t, f[3:0], f[3:0], v);
          chk_out({3'h0, t, tx(t, f[3:0], f[3:0], v, pend[f[1]])});
        end
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (c = 0; c < 8; c = c + 7) begin
      for (i = 0; i < 9; i++) begin
        chk_rd({c[2:0], 8'h62 + i[7:0]}, mir[i]);
      end
    end
    wr(11'h06F, 8'hFF);
    chk_rd(11'h06F, 8'h00);
    wr(11'h362, 8'hFF);
    wr(11'h363, 8'hFC);
    chk_rd(11'h362, 8'h7F);
    chk_rd(11'h363, 8'h00);
    chk_rd(11'h263, 8'h03);
    @(posedge clk);
    in_chan <= 3'h3;
    send(5'h00, 4'h0, 4'h0, 8'h5A);
    chk_out({3'h3, 5'h00, 8'h5A});
    in_chan <= 3'h0;
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    send(5'h05, 4'h1, 4'h1, 8'h11);
    send(5'h06, 4'h1, 4'h1, 8'h22);
    @(negedge clk);
    cmp({15'h0000, in_ready}, 16'h0000);
    hold <= 1'b0;
    chk_out({3'h0, 5'h05, 8'h11});
    chk_out({3'h0, 5'h06, 8'h22});
    for (i = 0; i < 13; i++) begin
      slow <= i[0];
      lost <= {7'h00, i == 12};
      wr(11'h062, modes[i]);
      wr(11'h063, rnd() & 8'h03);
      wr(11'h064, rnd() & 8'h1F);
      for (c = 5; c < 10; c++) begin
        wr(11'h060 + c[10:0], rnd() & 8'h0F);
      end
      wr(11'h06A, rnd() & 8'h0B);
      if (i == 6) begin
        pulse(1'b0);
        pulse(1'b0);
        pulse(1'b1);
        chk_rd(11'h070, {3'b110, modes[5][4:0]});
        mf(2'b11);
      end
      mf(2'b00);
      if (i == 0) begin
        d = rnd();
        e = tx(5'h00, 4'h1, 4'h1, d, 1'b0);
        wr(11'h063, ~mir[1] & 8'h03);
        send(5'h00, 4'h1, 4'h1, d);
        chk_out({3'h0, 5'h00, e});
      end
    end
    print_verdict;
  end
endmodule
`default_nettype wire
